// *** verilog/eeprom_serial_pkg.sv ***
/*
 constants, field layouts and state encoding shared by the serial memory slave front end.
 assumes a 10 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package eeprom_serial_pkg;

   // --------------------------------------------------------------------------
   // timing
   // --------------------------------------------------------------------------
   localparam int CLK_HZ = 10_000_000;
   localparam int WRITE_CYCLE_MS = 10;
   localparam int WRITE_CYCLES = WRITE_CYCLE_MS * (CLK_HZ / 1000);

   // --------------------------------------------------------------------------
   // register map (byte offsets)
   // --------------------------------------------------------------------------
   localparam logic [7:0] KEY_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] KEY_RESET = 8'hFF;
   localparam logic [7:0] KEY_UNLOCK = 8'h5F;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_LOAD_BIT = 1;
   localparam int STAT_REF_LSB = 2;

   // --------------------------------------------------------------------------
   // slave address and memory
   // --------------------------------------------------------------------------
   // arbitrary neutral value of the fixed device type code
   localparam logic [3:0] TYPE_CODE = 4'h6;
   localparam logic [15:0] CODE_LOCATION = 16'hFF09;
   localparam logic [7:0] CODE_MAX = 8'h07;
   localparam logic [2:0] REF_RESET = 3'h0;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] PAGE_BYTES = 4'h8;

   typedef enum logic [3:0] {
      LOAD_ADDR, LOAD_TAKE, IDLE, DEV_ADDR, ADDR_HIGH, ADDR_LOW, WRITE_DATA,
      READ_LOAD, READ_DATA, READ_HOLD, FLUSH, WRITE_WAIT
   } state_t;

endpackage : eeprom_serial_pkg

// *** verilog/eeprom_serial_slave.sv ***
/*
 two-wire serial slave front end of the nonvolatile memory: start/stop detection,
 slave address match, acknowledge, byte and page write, read data with master acknowledge,
 unlock key register and loading of the slave address code after reset.
 assumes a memory array outside with combinational read (MEM_RDATA follows MEM_ADDR) and
 a one-cycle write strobe; SCL and SDA arrive asynchronously and SDA is open drain.
*/
// Local design decisions: the placing of the registers and register access over Wishbone.
// Behaviour
// [R1] host unlocks key, then byte-writes code 0..7
// [R2] key register 8 bits, RW, resets all ones
// [R3] address high byte first, all bits MSB first
// [R4] SDA falls while SCL high: start
// [R5] SDA rises while SCL high: stop
// [R6] stop ends read or launches timed write
// [R7] eight data bits then ninth acknowledge bit
// [R8] drive SDA low ninth clock after write bytes
// [R9] release after read byte; low ack continues
// [R10] no ack then stop abandons the read
// [R11] no ack, no stop: stay released
// [R12] receive 4-bit type plus 3-bit code, direction
// [R13] select only when code equals reference
// [R14] copy stored code to reference after reset
// [R15] master waits while code is loading
// [R16] code defaults zero, 0..7, single byte only
// [R17] direction bit zero write, one read
// [R18] mismatch: no response, back to standby
// [R19] byte write acked; stop runs write, ignores bus
// [R20] more bytes: page write, low three bits increment
// [R21] low bits wrap in page; last byte wins
// [R22] internal write completes within ten milliseconds
// [R23] sample on SCL rise, change after fall
// [R24] addressed write during write cycle not acknowledged
// [R25] start and stop found by clocked sampling
`timescale 1ns/10ps
module eeprom_serial_slave #(
   parameter int WRITE_CYCLES = eeprom_serial_pkg::WRITE_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL_I,
   input wire logic SDA_I,
   output logic SDA_O,
   output logic SDA_OE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   output logic MEM_WE,
   output logic [15:0] MEM_ADDR,
   output logic [7:0] MEM_WDATA,
   input wire logic [7:0] MEM_RDATA
);

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      eeprom_serial_pkg::state_t state;
      logic [3:0] bit_cnt;
      logic ack_phase;
      logic [7:0] shift;
      logic sda_oe;
      logic master_ack;
      logic [15:0] addr;
      logic [3:0] n_bytes;
      logic [7:0][7:0] page_buf;
      logic [7:0] page_valid;
      logic [2:0] flush_idx;
      logic [16:0] wait_cnt;
      logic [7:0] key;
      logic [2:0] ref_code;
      logic wb_ack;
      logic [31:0] wb_dat;
      logic mem_we;
      logic [15:0] mem_addr;
      logic [7:0] mem_wdata;
   } state_reg_t;

   localparam state_reg_t STATE_RESET = '{
      scl_s1: 1'b1, scl_s2: 1'b1, scl_s3: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1, sda_s3: 1'b1,
      state: eeprom_serial_pkg::LOAD_ADDR, key: eeprom_serial_pkg::KEY_RESET,
      ref_code: eeprom_serial_pkg::REF_RESET, default: '0
   };

   state_reg_t st_reg;
   state_reg_t st_next;
   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;
   logic busy;
   logic code_write_ok;
   logic [31:0] rd_word;

   // --------------------------------------------------------------------------
   // bus line events, taken from the second and third sampling flops
   // --------------------------------------------------------------------------
   assign scl_rise = st_reg.scl_s2 & ~st_reg.scl_s3; // [R23]
   assign scl_fall = ~st_reg.scl_s2 & st_reg.scl_s3; // [R23]
   assign start_cond = st_reg.scl_s2 & st_reg.scl_s3 & st_reg.sda_s3 & ~st_reg.sda_s2; // [R4] [R25]
   assign stop_cond = st_reg.scl_s2 & st_reg.scl_s3 & ~st_reg.sda_s3 & st_reg.sda_s2; // [R5] [R25]
   assign busy = (st_reg.state == eeprom_serial_pkg::FLUSH) || (st_reg.state == eeprom_serial_pkg::WRITE_WAIT) ||
                 (st_reg.state == eeprom_serial_pkg::LOAD_ADDR) || (st_reg.state == eeprom_serial_pkg::LOAD_TAKE);
   // the code location only takes a first byte of 0..7 while the key is unlocked
   assign code_write_ok = (st_reg.key == eeprom_serial_pkg::KEY_UNLOCK) && (st_reg.n_bytes == 4'h0) &&
                          (st_reg.shift <= eeprom_serial_pkg::CODE_MAX); // [R1] [R16]

   // --------------------------------------------------------------------------
   // register read mux
   // --------------------------------------------------------------------------
   always_comb begin
      rd_word = 32'h0000_0000;
      case (WB_ADR_I)
         eeprom_serial_pkg::KEY_OFS: begin
            rd_word[7:0] = st_reg.key; // [R2]
         end
         eeprom_serial_pkg::STATUS_OFS: begin
            rd_word[eeprom_serial_pkg::STAT_BUSY_BIT] = (st_reg.state == eeprom_serial_pkg::FLUSH) ||
                                                        (st_reg.state == eeprom_serial_pkg::WRITE_WAIT);
            rd_word[eeprom_serial_pkg::STAT_LOAD_BIT] = (st_reg.state == eeprom_serial_pkg::LOAD_ADDR) ||
                                                        (st_reg.state == eeprom_serial_pkg::LOAD_TAKE);
            rd_word[eeprom_serial_pkg::STAT_REF_LSB +: 3] = st_reg.ref_code;
         end
         default: begin
            rd_word = 32'h0000_0000;
         end
      endcase
   end

   // --------------------------------------------------------------------------
   // next state
   // --------------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.scl_s1 = SCL_I;
      st_next.scl_s2 = st_reg.scl_s1;
      st_next.scl_s3 = st_reg.scl_s2;
      st_next.sda_s1 = SDA_I;
      st_next.sda_s2 = st_reg.sda_s1;
      st_next.sda_s3 = st_reg.sda_s2;
      st_next.mem_we = 1'b0;

      // classic Wishbone slave: answer one cycle after the strobe, drop ack the cycle after
      st_next.wb_ack = WB_CYC_I & WB_STB_I & ~st_reg.wb_ack;
      st_next.wb_dat = st_next.wb_ack ? rd_word : 32'h0000_0000;
      if (st_next.wb_ack && WB_WE_I && (WB_ADR_I == eeprom_serial_pkg::KEY_OFS) && WB_SEL_I[0]) begin
         st_next.key = WB_DAT_I[7:0]; // [R2]
      end

      if (busy) begin
         // bus lines are not looked at while loading or writing
         st_next.sda_oe = 1'b0; // [R15] [R19] [R24]
      end else if (start_cond) begin
         st_next.state = eeprom_serial_pkg::DEV_ADDR; // [R4]
         st_next.bit_cnt = 4'h0;
         st_next.ack_phase = 1'b0;
         st_next.sda_oe = 1'b0;
         st_next.n_bytes = 4'h0;
         st_next.page_valid = 8'h00;
      end else if (stop_cond) begin
         st_next.sda_oe = 1'b0;
         st_next.flush_idx = 3'h0;
         if ((st_reg.state == eeprom_serial_pkg::WRITE_DATA) && (st_reg.n_bytes != 4'h0)) begin
            st_next.state = eeprom_serial_pkg::FLUSH; // [R6] [R19]
         end else begin
            st_next.state = eeprom_serial_pkg::IDLE; // [R6] [R10]
         end
      end

      case (st_reg.state)
         eeprom_serial_pkg::LOAD_ADDR: begin
            st_next.state = eeprom_serial_pkg::LOAD_TAKE; // [R14]
         end
         eeprom_serial_pkg::LOAD_TAKE: begin
            st_next.ref_code = MEM_RDATA[2:0]; // [R14]
            st_next.state = eeprom_serial_pkg::IDLE;
         end
         eeprom_serial_pkg::DEV_ADDR, eeprom_serial_pkg::ADDR_HIGH, eeprom_serial_pkg::ADDR_LOW,
         eeprom_serial_pkg::WRITE_DATA: begin
            if (!start_cond && !stop_cond) begin
               if (scl_rise && !st_reg.ack_phase) begin
                  st_next.shift = {st_reg.shift[6:0], st_reg.sda_s2}; // [R3] [R23]
                  st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
               end else if (scl_fall && (st_reg.bit_cnt == eeprom_serial_pkg::BITS_PER_BYTE)) begin
                  if (!st_reg.ack_phase) begin
                     st_next.ack_phase = 1'b1;
                     st_next.sda_oe = 1'b1; // [R7] [R8]
                     case (st_reg.state)
                        eeprom_serial_pkg::DEV_ADDR: begin
                           if ((st_reg.shift[7:4] != eeprom_serial_pkg::TYPE_CODE) ||
                               (st_reg.shift[3:1] != st_reg.ref_code)) begin // [R12] [R13]
                              st_next.sda_oe = 1'b0; // [R18]
                              st_next.ack_phase = 1'b0;
                              st_next.state = eeprom_serial_pkg::IDLE;
                           end
                        end
                        eeprom_serial_pkg::ADDR_HIGH: begin
                           st_next.addr[15:8] = st_reg.shift; // [R3]
                        end
                        eeprom_serial_pkg::ADDR_LOW: begin
                           st_next.addr[7:0] = st_reg.shift; // [R3]
                        end
                        default: begin
                           // write data lands in the page buffer, last byte per slot wins
                           st_next.page_buf[st_reg.addr[2:0]] = st_reg.shift; // [R21]
                           st_next.page_valid[st_reg.addr[2:0]] = 1'b1;
                           if ((st_reg.addr == eeprom_serial_pkg::CODE_LOCATION) && !code_write_ok) begin
                              st_next.page_valid[st_reg.addr[2:0]] = 1'b0; // [R1] [R16]
                           end
                           if ((st_reg.n_bytes != 4'h0) &&
                               (st_reg.addr[15:3] == eeprom_serial_pkg::CODE_LOCATION[15:3])) begin
                              st_next.page_valid[eeprom_serial_pkg::CODE_LOCATION[2:0]] = 1'b0; // [R16]
                           end
                           st_next.addr[2:0] = st_reg.addr[2:0] + 3'h1; // [R20] [R21]
                           if (st_reg.n_bytes != eeprom_serial_pkg::PAGE_BYTES) begin
                              st_next.n_bytes = st_reg.n_bytes + 4'h1; // [R20]
                           end
                        end
                     endcase
                  end else begin
                     st_next.sda_oe = 1'b0;
                     st_next.ack_phase = 1'b0;
                     st_next.bit_cnt = 4'h0;
                     case (st_reg.state)
                        eeprom_serial_pkg::DEV_ADDR: begin
                           st_next.state = st_reg.shift[0] ? eeprom_serial_pkg::READ_LOAD :
                                                             eeprom_serial_pkg::ADDR_HIGH; // [R17]
                        end
                        eeprom_serial_pkg::ADDR_HIGH: begin
                           st_next.state = eeprom_serial_pkg::ADDR_LOW;
                        end
                        default: begin
                           st_next.state = eeprom_serial_pkg::WRITE_DATA; // [R19] [R20]
                        end
                     endcase
                  end
               end
            end
         end
         eeprom_serial_pkg::READ_LOAD: begin
            if (!start_cond && !stop_cond) begin
               st_next.shift = MEM_RDATA;
               st_next.sda_oe = ~MEM_RDATA[7]; // [R3]
               st_next.bit_cnt = 4'h0;
               st_next.ack_phase = 1'b0;
               st_next.state = eeprom_serial_pkg::READ_DATA;
            end
         end
         eeprom_serial_pkg::READ_DATA: begin
            if (!start_cond && !stop_cond) begin
               if (scl_rise) begin
                  if (st_reg.ack_phase) begin
                     st_next.master_ack = st_reg.sda_s2; // [R23]
                  end else begin
                     st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                  end
               end else if (scl_fall) begin
                  if (st_reg.ack_phase) begin
                     st_next.ack_phase = 1'b0;
                     if (!st_reg.master_ack) begin
                        st_next.addr[8:0] = st_reg.addr[8:0] + 9'h001; // [R9]
                        st_next.state = eeprom_serial_pkg::READ_LOAD;
                     end else begin
                        st_next.state = eeprom_serial_pkg::READ_HOLD; // [R11]
                     end
                  end else if (st_reg.bit_cnt == eeprom_serial_pkg::BITS_PER_BYTE) begin
                     st_next.sda_oe = 1'b0; // [R7] [R9]
                     st_next.ack_phase = 1'b1;
                  end else if (st_reg.bit_cnt != 4'h0) begin
                     st_next.shift = {st_reg.shift[6:0], 1'b0};
                     st_next.sda_oe = ~st_reg.shift[6]; // [R23]
                  end
               end
            end
         end
         eeprom_serial_pkg::READ_HOLD: begin
            if (!start_cond && !stop_cond) begin
               st_next.sda_oe = 1'b0; // [R11]
            end
         end
         eeprom_serial_pkg::FLUSH: begin
            // one buffered byte per cycle goes to the array, then the timed write
            if (st_reg.page_valid[st_reg.flush_idx]) begin
               st_next.mem_we = 1'b1; // [R6] [R19]
               st_next.mem_addr = {st_reg.addr[15:3], st_reg.flush_idx};
               st_next.mem_wdata = st_reg.page_buf[st_reg.flush_idx];
            end
            st_next.flush_idx = st_reg.flush_idx + 3'h1;
            if (st_reg.flush_idx == 3'h7) begin
               st_next.state = eeprom_serial_pkg::WRITE_WAIT;
               st_next.wait_cnt = 17'(WRITE_CYCLES - 8); // [R22]
               st_next.page_valid = 8'h00;
               st_next.n_bytes = 4'h0;
            end
         end
         eeprom_serial_pkg::WRITE_WAIT: begin
            if (st_reg.wait_cnt == 17'h0_0000) begin
               st_next.state = eeprom_serial_pkg::IDLE; // [R6] [R22]
            end else begin
               st_next.wait_cnt = st_reg.wait_cnt - 17'h0_0001;
            end
         end
         default: begin
         end
      endcase

      // array address follows the transfer pointer except while loading the code or flushing the page buffer
      if (st_next.state == eeprom_serial_pkg::LOAD_TAKE) begin
         st_next.mem_addr = eeprom_serial_pkg::CODE_LOCATION; // [R14]
      end else if (st_next.state != eeprom_serial_pkg::FLUSH && !st_next.mem_we) begin
         st_next.mem_addr = st_next.addr;
      end
   end

   // --------------------------------------------------------------------------
   // state register
   // --------------------------------------------------------------------------
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         st_reg <= STATE_RESET; // [R2] [R14]
      end else begin
         st_reg <= st_next;
      end
   end

   // --------------------------------------------------------------------------
   // outputs
   // --------------------------------------------------------------------------
   assign SDA_O = 1'b0;
   assign SDA_OE = st_reg.sda_oe;
   assign WB_DAT_O = st_reg.wb_dat;
   assign WB_ACK_O = st_reg.wb_ack;
   assign MEM_WE = st_reg.mem_we;
   assign MEM_ADDR = st_reg.mem_addr;
   assign MEM_WDATA = st_reg.mem_wdata;

endmodule : eeprom_serial_slave

// *** tb/eeprom_serial_slave_monitor.sv ***
/*
 concurrent checks on the ports of the serial memory slave front end.
 assumes one clock domain, CLK with asynchronous active high RST; bound to every slave instance.
*/
`timescale 1ns/10ps
module eeprom_serial_slave_monitor #(
   parameter int WRITE_CYCLES = eeprom_serial_pkg::WRITE_CYCLES
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic SCL_I,
   input wire logic SDA_I,
   input wire logic SDA_O,
   input wire logic SDA_OE,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [7:0] WB_ADR_I,
   input wire logic [31:0] WB_DAT_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic MEM_WE,
   input wire logic [15:0] MEM_ADDR,
   input wire logic [7:0] MEM_WDATA,
   input wire logic [7:0] MEM_RDATA
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   property p_wb_answer;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_wb_answer: assert property (p_wb_answer) else $error("register access not answered");
   property p_ack_single;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("register ack longer than one cycle");
   property p_dat_idle;
      !WB_ACK_O |-> WB_DAT_O == 32'h0000_0000;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_oe_scl_high;
      SCL_I && $past(SCL_I) && $past(SCL_I, 2) && $past(SCL_I, 3) |-> $stable(SDA_OE);
   endproperty
   a_oe_scl_high: assert property (p_oe_scl_high) else $error("data drive changed while clock high");
   property p_oe_hold;
      $rose(SDA_OE) |=> SDA_OE [*5];
   endproperty
   a_oe_hold: assert property (p_oe_hold) else $error("driven bit too short");
   property p_page_same;
      MEM_WE && $past(MEM_WE) |-> MEM_ADDR[15:3] == $past(MEM_ADDR[15:3]);
   endproperty
   a_page_same: assert property (p_page_same) else $error("page write left its page");
   property p_write_quiet;
      MEM_WE |=> !SDA_OE [*8];
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("bus answered during write cycle");
   property p_load_after_reset;
      $fell(RST) |-> ##[0:3] MEM_ADDR == eeprom_serial_pkg::CODE_LOCATION;
   endproperty
   a_load_after_reset: assert property (p_load_after_reset) else $error("code location not read");
endmodule : eeprom_serial_slave_monitor

bind eeprom_serial_slave eeprom_serial_slave_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) eeprom_serial_slave_monitor_inst (
   .CLK(CLK), .RST(RST), .SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE(SDA_OE),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_SEL_I(WB_SEL_I),
   .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
   .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA), .MEM_RDATA(MEM_RDATA));

// *** tb/link_master.sv ***
/*
 behavioural two-wire bus master: start, stop, byte send and receive, 800 ns link clock.
 assumes an 8-cycle bit at CLK and a pulled-up data wire resolved outside.
*/
`timescale 1ns/10ps
module link_master (
   input wire logic CLK,
   input wire logic SDA_IN,
   output logic SCL_OUT,
   output logic SDA_DRIVE
);
   // idle: clock stands high, data released
   initial begin
      SCL_OUT = 1'b1;
      SDA_DRIVE = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(posedge CLK);
   endtask : wait_clk

   // data changes mid low phase, sampled at end of high phase
   task automatic bit_xfer(input logic b, output logic r);
      wait_clk(2);
      SDA_DRIVE <= ~b;
      wait_clk(2);
      SCL_OUT <= 1'b1;
      wait_clk(4);
      r = SDA_IN;
      SCL_OUT <= 1'b0;
   endtask : bit_xfer

   task automatic start_cond;
      wait_clk(2);
      SDA_DRIVE <= 1'b0;
      wait_clk(2);
      SCL_OUT <= 1'b1;
      wait_clk(4);
      SDA_DRIVE <= 1'b1;
      wait_clk(4);
      SCL_OUT <= 1'b0;
   endtask : start_cond

   task automatic stop_cond;
      wait_clk(2);
      SDA_DRIVE <= 1'b1;
      wait_clk(2);
      SCL_OUT <= 1'b1;
      wait_clk(4);
      SDA_DRIVE <= 1'b0;
      wait_clk(4);
   endtask : stop_cond

   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
      bit_xfer(1'b1, ack);
   endtask : send_byte

   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_xfer(1'b1, r);
         b[i] = r;
      end
      bit_xfer(last, r);
   endtask : recv_byte
endmodule : link_master

// *** tb/test_eeprom_serial_slave.sv ***
/*
 self-checking bench of the serial memory slave: register bus, byte and page write, read, code change.
 assumes the slave, its package, the monitor and the link master model are compiled first.
*/
`timescale 1ns/10ps
module test_eeprom_serial_slave;
   localparam int WCYC = 200;
   logic clk, rst, scl, m_drive, sda, sda_o, sda_oe, wb_cyc, wb_stb, wb_we, wb_ack, mem_we, a;
   logic [3:0] wb_sel;
   logic [7:0] wb_adr, mem_wdata, mem_rdata, b, code_store;
   logic [15:0] mem_addr;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic [7:0] mem [0:511];
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   assign sda = (m_drive || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
   assign mem_rdata = (mem_addr == eeprom_serial_pkg::CODE_LOCATION) ? code_store : mem[mem_addr[8:0]];
   always @(posedge clk) begin
      if (mem_we && mem_addr == eeprom_serial_pkg::CODE_LOCATION) code_store <= mem_wdata;
      else if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
   end

   eeprom_serial_slave #(.WRITE_CYCLES(WCYC)) eeprom_serial_slave_inst (
      .CLK(clk), .RST(rst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe),
      .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we), .WB_SEL_I(wb_sel), .WB_ADR_I(wb_adr),
      .WB_DAT_I(wb_dat_i), .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack), .MEM_WE(mem_we),
      .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata), .MEM_RDATA(mem_rdata));
   link_master link_master_inst (.CLK(clk), .SDA_IN(sda), .SCL_OUT(scl), .SDA_DRIVE(m_drive));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test

   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fails++;
         finish_test();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_i <= wd;
      do
         @(posedge clk);
      while (wb_ack !== 1'b1);
      d = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask : wb_xfer

   task automatic addr_phase(input logic [2:0] code, input logic rw, input logic nak);
      link_master_inst.start_cond();
      link_master_inst.send_byte({eeprom_serial_pkg::TYPE_CODE, code, rw}, a);
      check(32'(a), 32'(nak));
   endtask : addr_phase

   task automatic set_addr(input logic [15:0] adr);
      link_master_inst.send_byte(adr[15:8], a);
      check(32'(a), 32'h0000_0000);
      link_master_inst.send_byte(adr[7:0], a);
      check(32'(a), 32'h0000_0000);
   endtask : set_addr

   task automatic do_reset;
      rst <= 1'b1;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (10) @(posedge clk);
   endtask : do_reset

   initial begin
      rst = 1'b1;
      {wb_cyc, wb_stb, wb_we} = 3'h0;
      wb_sel = 4'hF;
      wb_adr = 8'h00;
      wb_dat_i = 32'h0000_0000;
      code_store = 8'h00;
      for (int i = 0; i < 512; i++) mem[i] = 8'(i) ^ 8'h3C;
      do_reset();
      wb_xfer(1'b0, eeprom_serial_pkg::KEY_OFS, 32'h0000_0000);
      check(d, 32'h0000_00FF);
      wb_xfer(1'b1, eeprom_serial_pkg::KEY_OFS, 32'h0000_005F);
      wb_xfer(1'b0, eeprom_serial_pkg::KEY_OFS, 32'h0000_0000);
      check(d, 32'h0000_005F);
      wb_xfer(1'b1, 8'h08, 32'h0000_00AA);
      wb_xfer(1'b0, 8'h08, 32'h0000_0000);
      check(d, 32'h0000_0000);
      // byte write, then an addressed write while the cycle runs
      addr_phase(3'h0, 1'b0, 1'b0);
      set_addr(16'h0123);
      link_master_inst.send_byte(8'hA5, a);
      check(32'(a), 32'h0000_0000);
      link_master_inst.stop_cond();
      wb_xfer(1'b0, eeprom_serial_pkg::STATUS_OFS, 32'h0000_0000);
      check(d, 32'h0000_0001);
      addr_phase(3'h0, 1'b0, 1'b1);
      link_master_inst.stop_cond();
      repeat (WCYC + 50) @(posedge clk);
      check(32'(mem[9'h123]), 32'h0000_00A5);
      addr_phase(3'h1, 1'b0, 1'b1);
      link_master_inst.stop_cond();
      link_master_inst.start_cond();
      link_master_inst.send_byte({~eeprom_serial_pkg::TYPE_CODE, 4'h0}, a);
      check(32'(a), 32'h0000_0001);
      link_master_inst.stop_cond();
      // page write of ten bytes from slot 6 wraps within the page
      addr_phase(3'h0, 1'b0, 1'b0);
      set_addr(16'h0046);
      for (int i = 0; i < 10; i++) begin
         link_master_inst.send_byte(8'h10 + 8'(i), a);
         check(32'(a), 32'h0000_0000);
      end
      link_master_inst.stop_cond();
      repeat (WCYC + 50) @(posedge clk);
      for (int k = 0; k < 8; k++) check(32'(mem[9'h040 + 9'(k)]), 32'h12 + 32'(k));
      // random read of three bytes, master refuses the last
      addr_phase(3'h0, 1'b0, 1'b0);
      set_addr(16'h0047);
      addr_phase(3'h0, 1'b1, 1'b0);
      link_master_inst.recv_byte(1'b0, b);
      check(32'(b), 32'h0000_0019);
      link_master_inst.recv_byte(1'b0, b);
      check(32'(b), 32'(8'h48 ^ 8'h3C));
      link_master_inst.recv_byte(1'b1, b);
      check(32'(b), 32'(8'h49 ^ 8'h3C));
      link_master_inst.bit_xfer(1'b1, a);
      check(32'(a), 32'h0000_0001);
      link_master_inst.stop_cond();
      addr_phase(3'h0, 1'b0, 1'b0);
      set_addr(16'hFF09);
      link_master_inst.send_byte(8'h05, a);
      check(32'(a), 32'h0000_0000);
      link_master_inst.stop_cond();
      repeat (WCYC + 50) @(posedge clk);
      check(32'(code_store), 32'h0000_0005);
      do_reset();
      wb_xfer(1'b0, eeprom_serial_pkg::KEY_OFS, 32'h0000_0000);
      check(d, 32'h0000_00FF);
      wb_xfer(1'b0, eeprom_serial_pkg::STATUS_OFS, 32'h0000_0000);
      check(d, 32'h0000_0014);
      addr_phase(3'h0, 1'b0, 1'b1);
      link_master_inst.stop_cond();
      addr_phase(3'h5, 1'b0, 1'b0);
      link_master_inst.stop_cond();
      finish_test();
   end
endmodule : test_eeprom_serial_slave
